// file: pkg/pci_cfg_pm_map.vh
// Register offsets, field layouts, reset values and timing counts of the
// upper configuration header and the power-management capability.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef PCI_CFG_PM_MAP_VH
`define PCI_CFG_PM_MAP_VH

// Configuration dword offsets (byte addresses, dword aligned).
`define OFF_UNUSED_BASE_SLOT_FIVE   8'h24
`define OFF_RESERVED_DWORD_28       8'h28
`define OFF_SUBSYSTEM_IDENTITY      8'h2C
`define OFF_EXPANSION_ROM_BASE      8'h30
`define OFF_CAPABILITY_LIST_POINTER 8'h34
`define OFF_RESERVED_DWORD_38       8'h38
`define OFF_INTERRUPT_ROUTING       8'h3C
`define OFF_POWER_CAPABILITY        8'h40
`define OFF_POWER_CONTROL_STATUS    8'h44

// Fixed read values.
`define CAP_POINTER_VALUE     8'h40
`define INT_PIN_VALUE         8'h01
`define CAP_ID_VALUE          8'h01
`define CAP_NEXT_VALUE        8'h00
`define EVENT_SUPPORT_VALUE   5'h08
`define CLOCK_REQUIRED_VALUE  1'h1
`define PM_VERSION_VALUE      3'h2

// Control/status field positions.
`define BIT_EVENT_STATUS  15
`define BIT_EVENT_ENABLE  8
`define POWER_STATE_HI    1
`define POWER_STATE_LO    0

// Power-state encodings and reset values.
`define PSTATE_D0         2'h0
`define PSTATE_D3HOT      2'h3
`define RESET_POWER_STATE 2'h0
`define RESET_INT_LINE    8'h00
`define RESET_SUBSYSTEM   32'h00000000

// Serial-memory load window, in PCI clocks (2 to the 16th).
`define LOAD_WINDOW_LOG2  16

`endif

// file: logic/pci_config_power_mgmt.v
// Upper configuration header (0x24..0x3C) and the power-management
// capability (0x40, 0x44) with D0/D3hot tracking and wake-event logic.
// Assumes a configuration decoder that presents one dword access per cycle
// and a serial-memory loader that hands over the subsystem dword.
//
// Operation
// [R01] Unused dwords 0x24 0x28 0x30 0x38 read zero.
// [R02] Subsystem dword resets zero, loaded from memory only.
// [R03] Capability pointer reads 0x40, upper bits zero.
// [R04] Interrupt pin 0x01, line byte host writable.
// [R05] Capability id 0x01, next pointer 0x00.
// [R06] Upper capability half: support, clock, version fixed.
// [R07] Data, bridge bytes and reserved bits read zero.
// [R08] Two-bit power state field, reset D0.
// [R09] Event output asserts in D3hot when enabled.
// [R10] Wake: receive falling edge or modem delta.
// [R11] Event status sets regardless of enable.
// [R12] Writing one clears event status.
// [R13] D3hot: config only, no memory, no interrupt.
// [R14] Receive and flow control keep running in D3hot.
// [R15] D3hot to D0 enters active, keeps registers.
// [R16] Bus drivers disabled during D3hot to D0.
// [R17] Power-up in D0 uninitialized, then active.
// [R18] D0 active answers all, interrupts allowed.
// [R19] Reset restores every default, no cold event.
// [R20] Sleep works independent of power state.
// [R21] Software should avoid sleep in D3hot.
// [R22] Memory load after reset if select high.
// [R23] Encodings 00 D0, 11 D3hot; others ignored.
`timescale 1ns/1ps
`include "pci_cfg_pm_map.vh"

module pci_config_power_mgmt #(
    parameter CHANNELS   = 8,
    parameter LOAD_LOG2  = `LOAD_WINDOW_LOG2,
    parameter DRV_HOLD   = 4
) (
    // Clock and reset.
    input  wire                  core_clk,
    input  wire                  sys_rst,
    // Configuration access port, one dword per cycle.
    input  wire                  cfgRead,
    input  wire                  cfgWrite,
    input  wire [7:0]            cfgAddr,
    input  wire [3:0]            cfgByteEn,
    input  wire [31:0]           cfgWriteData,
    output reg  [31:0]           cfgReadData,
    output reg                   cfgReadValid,
    // Memory-space and interrupt requests from the functional core.
    input  wire                  memRequest,
    input  wire                  coreInterrupt,
    output reg                   memAccept,
    output reg                   interruptOut,
    output reg                   busDriveEnable,
    // Initialisation done by system software.
    input  wire                  softwareInitDone,
    // Serial-memory loader.
    input  wire                  serial_memory_select,
    input  wire                  loadWordValid,
    input  wire [31:0]           loadWord,
    output reg                   loadActive,
    output reg                   loadTimeout,
    // Wake sources.
    input  wire [CHANNELS-1:0]   rxLine,
    input  wire [4*CHANNELS-1:0] modem_status,
    // Sleep request from the functional core and state outputs.
    input  wire                  sleepRequest,
    output reg                   sleepEnable,
    output reg                   pmeEvent_n,
    output reg  [1:0]            powerStateOut,
    output reg                   d0Active
);

    // Functional-state codes.
    localparam ST_D0_UNINIT = 2'h0;
    localparam ST_D0_ACTIVE = 2'h1;
    localparam ST_D3_HOT    = 2'h2;
    localparam ST_WAKING    = 2'h3;

    reg [1:0]                 pmState;
    reg [1:0]                 power_state_field;
    reg                       event_enable_bit;
    reg                       event_status_bit;
    reg [7:0]                 interruptLine;
    reg [31:0]                subsystemIdentity;
    reg [CHANNELS-1:0]        rxPrev;
    reg [4*CHANNELS-1:0]      modemPrev;
    reg                       rstSeen;
    reg [LOAD_LOG2:0]         loadCount;
    reg [7:0]                 holdCount;
    reg [31:0]                next_readData;

    wire       inD3hot;
    wire       wakeEvent;
    wire       writeCsr;
    wire       stateWrite;
    wire [1:0] writtenState;

    // Byte-lane merge used by the interrupt line byte.
    function [7:0] merge_byte;
        input       enable;
        input [7:0] oldValue;
        input [7:0] newValue;
        begin
            merge_byte = enable ? newValue : oldValue;
        end
    endfunction

    assign inD3hot      = (pmState == ST_D3_HOT);
    // A start bit is a falling receive line; modem deltas count on setting.
    assign wakeEvent    = (|(rxPrev & ~rxLine)) |
                          (|(modem_status & ~modemPrev)); // [R10]
    assign writeCsr     = cfgWrite && (cfgAddr == `OFF_POWER_CONTROL_STATUS);
    assign writtenState = cfgWriteData[`POWER_STATE_HI:`POWER_STATE_LO];
    // Unsupported encodings are dropped so the field never holds D1/D2.
    assign stateWrite   = writeCsr && cfgByteEn[0] &&
                          ((writtenState == `PSTATE_D0) ||
                           (writtenState == `PSTATE_D3HOT)); // [R23]

    // Edge history of the wake inputs; runs in every state so that receive
    // and flow control on the channels are never frozen.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxPrev    <= {CHANNELS{1'b1}};
            modemPrev <= {4*CHANNELS{1'b0}};
        end else begin
            rxPrev    <= rxLine;     // [R14]
            modemPrev <= modem_status;
        end
    end

    // Power-state field and functional state sequence.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_state_field <= `RESET_POWER_STATE; // [R08]
            pmState           <= ST_D0_UNINIT;       // [R17] [R19]
            holdCount         <= 8'h00;
        end else begin
            if (stateWrite) begin
                power_state_field <= writtenState; // [R08]
            end
            case (pmState)
                ST_D0_UNINIT: begin
                    if (stateWrite && writtenState == `PSTATE_D3HOT) begin
                        pmState <= ST_D3_HOT;
                    end else if (softwareInitDone) begin
                        pmState <= ST_D0_ACTIVE; // [R17]
                    end
                end
                ST_D0_ACTIVE: begin
                    if (stateWrite && writtenState == `PSTATE_D3HOT) begin
                        pmState <= ST_D3_HOT;
                    end
                end
                ST_D3_HOT: begin
                    if (stateWrite && writtenState == `PSTATE_D0) begin
                        pmState   <= ST_WAKING;
                        holdCount <= DRV_HOLD[7:0];
                    end
                end
                ST_WAKING: begin
                    // Drivers stay off for the hold; registers untouched.
                    if (holdCount <= 8'h01) begin
                        pmState <= ST_D0_ACTIVE; // [R15]
                    end else begin
                        holdCount <= holdCount - 8'h01;
                    end
                end
                default: begin
                    pmState <= ST_D0_UNINIT;
                end
            endcase
        end
    end

    // Host-writable control bits; event status set wins over its clear.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            event_enable_bit <= 1'b0;
            event_status_bit <= 1'b0;
            interruptLine    <= `RESET_INT_LINE;
        end else begin
            if (writeCsr && cfgByteEn[1]) begin
                event_enable_bit <= cfgWriteData[`BIT_EVENT_ENABLE]; // [R09]
            end
            if (inD3hot && wakeEvent) begin
                event_status_bit <= 1'b1; // [R11]
            end else if (writeCsr && cfgByteEn[1] &&
                         cfgWriteData[`BIT_EVENT_STATUS]) begin
                event_status_bit <= 1'b0; // [R12]
            end
            if (cfgWrite && cfgAddr == `OFF_INTERRUPT_ROUTING) begin
                interruptLine <= merge_byte(cfgByteEn[0], interruptLine,
                                            cfgWriteData[7:0]); // [R04]
            end
        end
    end

    // Serial-memory load window; the select pin is sampled at the first
    // clock after reset release, never under the reset itself.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rstSeen           <= 1'b0;
            loadActive        <= 1'b0;
            loadTimeout       <= 1'b0;
            loadCount         <= {(LOAD_LOG2+1){1'b0}};
            subsystemIdentity <= `RESET_SUBSYSTEM; // [R02]
        end else begin
            rstSeen <= 1'b1;
            if (!rstSeen) begin
                loadActive <= serial_memory_select; // [R22]
                loadCount  <= {(LOAD_LOG2+1){1'b0}};
            end else if (loadActive) begin
                if (loadWordValid) begin
                    subsystemIdentity <= loadWord; // [R02]
                    loadActive        <= 1'b0;
                end else if (loadCount[LOAD_LOG2]) begin
                    loadActive  <= 1'b0; // [R22]
                    loadTimeout <= 1'b1;
                end else begin
                    loadCount <= loadCount + {{LOAD_LOG2{1'b0}}, 1'b1};
                end
            end
        end
    end

    // Read mux; every offset not listed, including 0x24/0x28/0x30/0x38,
    // reads as zero.
    always @* begin
        next_readData = 32'h00000000; // [R01]
        case (cfgAddr)
            `OFF_SUBSYSTEM_IDENTITY: begin
                next_readData = subsystemIdentity; // [R02]
            end
            `OFF_CAPABILITY_LIST_POINTER: begin
                next_readData = {24'h000000, `CAP_POINTER_VALUE}; // [R03]
            end
            `OFF_INTERRUPT_ROUTING: begin
                next_readData = {16'h0000, `INT_PIN_VALUE, interruptLine}; // [R04]
            end
            `OFF_POWER_CAPABILITY: begin
                next_readData = {`EVENT_SUPPORT_VALUE, 7'h00,
                                 `CLOCK_REQUIRED_VALUE, `PM_VERSION_VALUE,
                                 `CAP_NEXT_VALUE, `CAP_ID_VALUE}; // [R05] [R06]
            end
            `OFF_POWER_CONTROL_STATUS: begin
                next_readData = {16'h0000, event_status_bit, 6'h00,
                                 event_enable_bit, 6'h00,
                                 power_state_field}; // [R07]
            end
            default: begin
                next_readData = 32'h00000000; // [R01]
            end
        endcase
    end

    // Registered outputs: read data, gates and the event pin.
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgReadData    <= 32'h00000000;
            cfgReadValid   <= 1'b0;
            memAccept      <= 1'b0;
            interruptOut   <= 1'b0;
            busDriveEnable <= 1'b0;
            sleepEnable    <= 1'b0;
            pmeEvent_n     <= 1'b1; // [R19]
            powerStateOut  <= `RESET_POWER_STATE;
            d0Active       <= 1'b0;
        end else begin
            // Configuration reads are answered in every state but waking.
            cfgReadValid   <= cfgRead && (pmState != ST_WAKING); // [R13]
            cfgReadData    <= (cfgRead && pmState != ST_WAKING) ?
                              next_readData : 32'h00000000;
            memAccept      <= memRequest && (pmState == ST_D0_ACTIVE ||
                              pmState == ST_D0_UNINIT); // [R13] [R18]
            interruptOut   <= coreInterrupt && !inD3hot &&
                              (pmState != ST_WAKING); // [R13] [R18]
            busDriveEnable <= (pmState != ST_WAKING); // [R16]
            // Sleep follows its own request whatever the power state.
            sleepEnable    <= sleepRequest; // [R20]
            // Held in D3hot while status and enable stand; status clear drops it.
            pmeEvent_n     <= !(inD3hot && event_enable_bit &&
                                (event_status_bit || wakeEvent)); // [R09]
            powerStateOut  <= power_state_field;
            d0Active       <= (pmState == ST_D0_ACTIVE);
        end
    end

endmodule

// file: tb/pci_pm_monitor.sv
// Checker on the top module's ports for configuration reads and power state.
// Assumes the port names of the top module; it is bound below.
`timescale 1ns/1ps
module pci_pm_monitor (
    // Clock and reset.
    input wire        core_clk,
    input wire        sys_rst,
    // Watched ports.
    input wire        cfgRead,
    input wire [7:0]  cfgAddr,
    input wire [31:0] cfgReadData,
    input wire        cfgReadValid,
    input wire        memAccept,
    input wire        interruptOut,
    input wire        pmeEvent_n,
    input wire [1:0]  powerStateOut,
    input wire        d0Active
);
    // One domain, so clock and reset are named once.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Reads are judged only when answered, since a waking read gets no answer.
    chk_unused_zero: assert property (
        cfgRead && cfgAddr inside {8'h24, 8'h28, 8'h30, 8'h38} ##1 cfgReadValid
        |-> cfgReadData == 32'h0) else $error("unused dword not zero");
    chk_cap_word: assert property (
        cfgRead && cfgAddr == 8'h40 ##1 cfgReadValid |-> cfgReadData == 32'h400A0001)
        else $error("capability dword wrong");
    chk_d3_answer: assert property (
        cfgRead && powerStateOut == 2'h3 |=> cfgReadValid) else $error("no answer in D3hot");
    chk_mem_gated: assert property (
        $past(powerStateOut) == 2'h3 |-> !memAccept) else $error("memory taken in D3hot");
    chk_irq_quiet: assert property (
        $past(powerStateOut) == 2'h3 |-> !interruptOut) else $error("interrupt in D3hot");
    chk_event_state: assert property (
        $fell(pmeEvent_n) |-> powerStateOut == 2'h3) else $error("event outside D3hot");
    chk_state_legal: assert property (
        $changed(powerStateOut) |-> powerStateOut inside {2'h0, 2'h3})
        else $error("unsupported power state");
    chk_active_d0: assert property (
        d0Active |-> powerStateOut == 2'h0) else $error("active outside D0");
endmodule
bind pci_config_power_mgmt pci_pm_monitor u_pci_pm_monitor (.core_clk, .sys_rst, .cfgRead,
    .cfgAddr, .cfgReadData, .cfgReadValid, .memAccept, .interruptOut, .pmeEvent_n,
    .powerStateOut, .d0Active);

// file: tb/host_cfg_model.sv
// Host bridge model: one configuration dword per access.
// Assumes the device takes a request at the edge that sees it high.
`timescale 1ns/1ps
module host_cfg_model (
    // Clock.
    input wire          core_clk,
    // Configuration port.
    output logic        cfgRead = 1'b0,
    output logic        cfgWrite = 1'b0,
    output logic [7:0]  cfgAddr = 8'h00,
    output logic [3:0]  cfgByteEn = 4'h0,
    output logic [31:0] cfgWriteData = 32'h0,
    input wire [31:0]   cfgReadData,
    input wire          cfgReadValid
);
    // Request stands for one edge; afterwards idle address and data show the inverse,
    // so a stale address can never look like a fresh request.
    task access(input logic w, input logic [7:0] a, input logic [31:0] d,
                input logic [3:0] be, output logic [31:0] q, output logic v);
        @(posedge core_clk);
        cfgWrite <= w;
        cfgRead <= !w;
        cfgAddr <= a;
        cfgByteEn <= be;
        cfgWriteData <= d;
        @(posedge core_clk);
        cfgWrite <= 1'b0;
        cfgRead <= 1'b0;
        cfgAddr <= ~a;
        cfgWriteData <= ~d;
        @(posedge core_clk);
        q = cfgReadData;
        v = cfgReadValid;
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the upper configuration header and power management.
// Assumes the host model owns the configuration port and the bench the rest.
`timescale 1ns/1ps
module testbench;
    // Bench-driven inputs and read results.
    logic core_clk = 1'b0, sys_rst = 1'b1, memRequest = 1'b0, coreInterrupt = 1'b0;
    logic softwareInitDone = 1'b0, serial_memory_select = 1'b1, loadWordValid = 1'b0;
    logic sleepRequest = 1'b0, rdValid;
    logic [7:0] rxLine = 8'hFF;
    logic [31:0] loadWord = 32'h5AC3A53C, modem_status = 32'h0, rdData;
    // Observed outputs and counters.
    logic cfgRead, cfgWrite, cfgReadValid, memAccept, interruptOut, busDriveEnable;
    logic loadActive, loadTimeout, sleepEnable, pmeEvent_n, d0Active;
    logic [7:0] cfgAddr;
    logic [3:0] cfgByteEn;
    logic [31:0] cfgWriteData, cfgReadData;
    logic [1:0] powerStateOut;
    int miscompares = 0, check_count = 0, cycles = 0;
    // Fixed dwords and their values after reset.
    logic [7:0] offs [8] = '{8'h24, 8'h28, 8'h30, 8'h38, 8'h34, 8'h40, 8'h3C, 8'h44};
    logic [31:0] vals [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h40, 32'h400A0001, 32'h100, 32'h0};

    pci_config_power_mgmt #(.LOAD_LOG2(4)) u_pci_config_power_mgmt (.core_clk, .sys_rst,
        .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWriteData, .cfgReadData, .cfgReadValid,
        .memRequest, .coreInterrupt, .memAccept, .interruptOut, .busDriveEnable,
        .softwareInitDone, .serial_memory_select, .loadWordValid, .loadWord, .loadActive,
        .loadTimeout, .rxLine, .modem_status, .sleepRequest, .sleepEnable, .pmeEvent_n,
        .powerStateOut, .d0Active);
    host_cfg_model u_host_cfg_model (.core_clk, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn,
        .cfgWriteData, .cfgReadData, .cfgReadValid);

    // 50 MHz clock.
    initial forever #10 core_clk = ~core_clk;
    // The scenarios need under 160 cycles; a hang is cut short well after.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) miscompares++;
        if (cycles == 3000) end_sim();
    end
    task check_val(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) miscompares++;
        if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
    endtask
    // Writes when w is set, else reads and compares; an unanswered read is unknown.
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        u_host_cfg_model.access(w, a, d, be, rdData, rdValid);
        if (!w) check_val("config read", d, (rdValid === 1'b1) ? rdData : 32'hXXXXXXXX);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Loader, fixed dwords, ignored writes and full service in D0.
    task test_map;
        repeat (2) @(posedge core_clk);
        check_val("loadActive", 1, loadActive);
        loadWordValid <= 1'b1;
        softwareInitDone <= 1'b1;
        memRequest <= 1'b1;
        coreInterrupt <= 1'b1;
        sleepRequest <= 1'b1;
        @(posedge core_clk);
        loadWordValid <= 1'b0;
        acc(1, 8'h2C, 32'hFFFFFFFF, 4'hF);
        acc(0, 8'h2C, 32'h5AC3A53C, 4'h0);
        acc(1, 8'h24, 32'hFFFFFFFF, 4'hF);
        foreach (offs[i]) acc(0, offs[i], vals[i], 4'h0);
        check_val("d0Active", 1, d0Active);
        check_val("memAccept", 1, memAccept);
        check_val("interruptOut", 1, interruptOut);
        check_val("sleepEnable", 1, sleepEnable);
        sleepRequest <= 1'b0;
        acc(1, 8'h3C, 32'hFFFFFFA5, 4'hF);
        acc(0, 8'h3C, 32'h1A5, 4'h0);
        $display("test_map done");
    endtask
    // D3hot entry, both wake sources, status clearing and the return to D0.
    task test_d3;
        acc(1, 8'h44, 32'h103, 4'h3);
        rxLine <= 8'hFB;
        @(posedge core_clk);
        check_val("memAccept", 0, memAccept);
        check_val("interruptOut", 0, interruptOut);
        rxLine <= 8'hFF;
        acc(0, 8'h44, 32'h8103, 4'h0);
        check_val("pmeEvent_n", 0, pmeEvent_n);
        acc(1, 8'h44, 32'h8103, 4'h3);
        acc(0, 8'h44, 32'h103, 4'h0);
        check_val("pmeEvent_n", 1, pmeEvent_n);
        acc(1, 8'h44, 32'h3, 4'h3);
        modem_status <= 32'h20;
        acc(0, 8'h44, 32'h8003, 4'h0);
        check_val("pmeEvent_n", 1, pmeEvent_n);
        acc(1, 8'h44, 32'h8001, 4'h3);
        acc(0, 8'h44, 32'h3, 4'h0);
        acc(1, 8'h44, 32'h0, 4'h1);
        @(posedge core_clk);
        check_val("busDriveEnable", 0, busDriveEnable);
        repeat (6) @(posedge core_clk);
        check_val("busDriveEnable", 1, busDriveEnable);
        check_val("d0Active", 1, d0Active);
        acc(0, 8'h3C, 32'h1A5, 4'h0);
        $display("test_d3 done");
    endtask
    // A reset taken in D3hot brings back every default.
    task test_rst;
        acc(1, 8'h44, 32'h103, 4'h3);
        softwareInitDone <= 1'b0;
        serial_memory_select <= 1'b0;
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        check_val("pmeEvent_n", 1, pmeEvent_n);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check_val("d0Active", 0, d0Active);
        check_val("loadActive", 0, loadActive);
        foreach (offs[i]) acc(0, offs[i], vals[i], 4'h0);
        acc(0, 8'h2C, 32'h0, 4'h0);
        check_val("loadTimeout", 0, loadTimeout);
        // A selected memory that never answers must close its window.
        serial_memory_select <= 1'b1;
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check_val("loadActive", 1, loadActive);
        repeat (20) @(posedge core_clk);
        check_val("loadActive", 0, loadActive);
        check_val("loadTimeout", 1, loadTimeout);
        acc(0, 8'h2C, 32'h0, 4'h0);
        $display("test_rst done");
    endtask
    // Reset for 12 cycles, then the scenarios in turn.
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        test_map();
        test_d3();
        test_rst();
        end_sim();
    end
endmodule
